// >>> rate_generator.sv
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/1ns
module rate_generator #(
    parameter logic [3:0] TWO_WIRE_N  = rate_gen_pkg::TWO_WIRE_CLOCKS,
    parameter logic [3:0] FOUR_WIRE_N = rate_gen_pkg::FOUR_WIRE_CLOCKS
) (
    input  wire logic                   core_clk,     // 20 MHz core clock
    input  wire logic                   resetn,       // async reset
    input  wire rate_gen_pkg::reg_req_t req,          // register request
    output logic [7:0]                  rd_data,      // read data, next cycle
    input  wire logic                   scl_sense,    // clock line level
    output logic                        scl_value,    // clock line drive
    output logic                        scl_enable,   // clock line enable
    input  wire logic                   sda_sense,    // data line level
    output logic                        sda_value,    // data line drive
    output logic                        sda_enable,   // data line enable
    output logic                        rollover,     // counter at zero
    output logic                        op_done,      // operation complete
    output logic                        busy          // sequencer active
);
    import rate_gen_pkg::*;

    // ------------------------------------------------------------------
    // line synchronisers
    // ------------------------------------------------------------------
    logic [1:0] scl_sync_q;
    logic [1:0] sda_sync_q;
    logic       scl_s;
    logic       sda_s;

    // both lines are asynchronous to core_clk; only stage 2 is read
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            scl_sync_q <= 2'b11;
            sda_sync_q <= 2'b11;
        end else begin
            scl_sync_q <= {scl_sync_q[0], scl_sense};
            sda_sync_q <= {sda_sync_q[0], sda_sense};
        end
    end
    assign scl_s = scl_sync_q[1];
    assign sda_s = sda_sync_q[1];

    // ------------------------------------------------------------------
    // register file
    // ------------------------------------------------------------------
    logic [7:0] reload_q, reload_d;
    logic [7:0] buffer_q, buffer_d;
    logic       enable_q, enable_d;
    logic       two_wire_q, two_wire_d;
    logic       done_q, done_d;
    logic [7:0] rd_data_q, rd_data_d;
    logic       buf_wr;
    logic       start_cmd;
    logic       done_pulse;
    seq_state_t state_q, state_d;
    logic       scl_q, scl_d;
    logic       sda_low_q, sda_low_d;

    assign busy   = (state_q != SEQ_IDLE);
    // a buffer write only counts when the port is enabled and idle
    assign buf_wr = req.wr && req.addr == REG_TRANSFER && enable_q && !busy;
    assign start_cmd = req.wr && req.addr == REG_CONTROL && enable_q
                     && req.wdata[CTRL_TWO_WIRE_BIT]
                     && req.wdata[CTRL_START_BIT] && !busy;

    // stores, sticky done flag and read mux
    always_comb begin
        reload_d   = reload_q;
        buffer_d   = buffer_q;
        enable_d   = enable_q;
        two_wire_d = two_wire_q;
        done_d     = done_q;
        rd_data_d  = 8'h00;
        if (req.wr) begin
            unique case (req.addr)
                REG_RATE_RELOAD: reload_d = req.wdata;
                REG_TRANSFER: begin
                    if (buf_wr) begin
                        buffer_d = req.wdata;
                    end
                end
                REG_CONTROL: begin
                    enable_d   = req.wdata[CTRL_ENABLE_BIT];
                    two_wire_d = req.wdata[CTRL_TWO_WIRE_BIT];
                end
                REG_STATUS: begin
                    if (req.wdata[STAT_DONE_BIT]) begin
                        done_d = 1'b0;
                    end
                end
            endcase
        end
        // set beats clear when both land together
        if (done_pulse) begin
            done_d = 1'b1;
        end
        if (req.rd) begin
            unique case (req.addr)
                REG_RATE_RELOAD: rd_data_d = reload_q;
                REG_TRANSFER:    rd_data_d = buffer_q;
                REG_CONTROL: begin
                    rd_data_d[CTRL_ENABLE_BIT]   = enable_q;
                    rd_data_d[CTRL_TWO_WIRE_BIT] = two_wire_q;
                end
                REG_STATUS: begin
                    rd_data_d[STAT_BUSY_BIT] = busy;
                    rd_data_d[STAT_SCL_BIT]  = scl_q;
                    rd_data_d[STAT_SDA_BIT]  = sda_low_q;
                    rd_data_d[STAT_DONE_BIT] = done_q;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            reload_q   <= RELOAD_RESET;
            buffer_q   <= BUFFER_RESET;
            enable_q   <= 1'b0;
            two_wire_q <= 1'b0;
            done_q     <= 1'b0;
            rd_data_q  <= 8'h00;
        end else begin
            reload_q   <= reload_d;
            buffer_q   <= buffer_d;
            enable_q   <= enable_d;
            two_wire_q <= two_wire_d;
            done_q     <= done_d;
            rd_data_q  <= rd_data_d;
        end
    end
    assign rd_data = rd_data_q;

    // ------------------------------------------------------------------
    // rate counter
    // ------------------------------------------------------------------
    logic         reload;
    logic         run;
    logic [7:0]   count;
    // one counter for both host modes; codes below 0x03 are the
    // caller's problem in two-wire mode, no clamp is applied
    rate_counter #(
        .W        (RELOAD_W)
    ) i_rate_counter (
        .core_clk (core_clk),
        .resetn   (resetn),
        .reload   (reload),
        .run      (run),
        .value    (reload_q),
        .count    (count),
        .rollover (rollover)
    );

    // ------------------------------------------------------------------
    // clock sequencer
    // ------------------------------------------------------------------
    logic [3:0] per_q, per_d;
    logic [3:0] last_per;

    assign last_per = two_wire_q ? TWO_WIRE_N - 4'h1 : FOUR_WIRE_N - 4'h1;

    // one period is a low half and a high half, each one rollover;
    // a core cycle is half an instruction cycle, so the rate is
    // instruction rate over reload plus one
    // no slew shaping at the faster rates
    always_comb begin
        state_d    = state_q;
        scl_d      = scl_q;
        sda_low_d  = sda_low_q;
        per_d      = per_q;
        reload     = 1'b0;
        run        = 1'b0;
        done_pulse = 1'b0;
        unique case (state_q)
            SEQ_IDLE: begin
                if (start_cmd) begin
                    scl_d     = 1'b1;
                    sda_low_d = 1'b0;
                    state_d   = SEQ_ST_WAIT;
                end else if (buf_wr) begin
                    per_d   = 4'h0;
                    scl_d   = 1'b0;
                    reload  = 1'b1;
                    state_d = SEQ_LOW;
                end
            end
            SEQ_ST_WAIT: begin
                if (sda_s && scl_s) begin
                    reload  = 1'b1;
                    state_d = SEQ_ST_HOLD;
                end
            end
            SEQ_ST_HOLD: begin
                run = 1'b1;
                if (!sda_s || rollover) begin
                    sda_low_d = 1'b1;
                    reload    = 1'b1;
                    state_d   = SEQ_ST_TAIL;
                end
            end
            SEQ_ST_TAIL: begin
                run = 1'b1;
                if (rollover) begin
                    scl_d      = 1'b0;
                    done_pulse = 1'b1;
                    state_d    = SEQ_IDLE;
                end
            end
            SEQ_LOW: begin
                run = 1'b1;
                if (rollover) begin
                    scl_d = 1'b1;
                    if (two_wire_q) begin
                        state_d = SEQ_HI_WAIT;
                    end else begin
                        reload  = 1'b1;
                        state_d = SEQ_HIGH;
                    end
                end
            end
            SEQ_HI_WAIT: begin
                // a slow party may hold the line low to stretch it
                if (scl_s) begin
                    reload  = 1'b1;
                    state_d = SEQ_HIGH;
                end
            end
            SEQ_HIGH: begin
                run = 1'b1;
                if (rollover) begin
                    scl_d = 1'b0;
                    if (per_q == last_per) begin
                        done_pulse = 1'b1;
                        state_d    = SEQ_IDLE;
                    end else begin
                        per_d   = per_q + 4'h1;
                        reload  = 1'b1;
                        state_d = SEQ_LOW;
                    end
                end
            end
            default: state_d = SEQ_IDLE;
        endcase
        // disabling the port aborts at once and frees both lines
        if (!enable_q) begin
            state_d   = SEQ_IDLE;
            scl_d     = 1'b0;
            sda_low_d = 1'b0;
            reload    = 1'b0;
            run       = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_q   <= SEQ_IDLE;
            scl_q     <= 1'b0;
            sda_low_q <= 1'b0;
            per_q     <= 4'h0;
        end else begin
            state_q   <= state_d;
            scl_q     <= scl_d;
            sda_low_q <= sda_low_d;
            per_q     <= per_d;
        end
    end

    // ------------------------------------------------------------------
    // pins
    // ------------------------------------------------------------------
    // two-wire: open drain, enable means pull low; four-wire: clock push-pull, data not driven
    assign scl_value  = two_wire_q ? 1'b0 : scl_q;
    assign scl_enable = enable_q && (two_wire_q ? !scl_q : 1'b1);
    assign sda_value  = 1'b0;
    assign sda_enable = enable_q && two_wire_q && sda_low_q;
    assign op_done    = done_pulse;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    logic [8:0] hi_len_q;
    logic [7:0] loaded_q;

    // length of the high half and the value last loaded
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            hi_len_q <= 9'h000;
            loaded_q <= 8'h00;
        end else begin
            hi_len_q <= (state_q == SEQ_HIGH) ? hi_len_q + 9'h001 : 9'h000;
            loaded_q <= reload ? reload_q : loaded_q;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    sequence start_request_s;
        start_cmd ##1 (state_q == SEQ_ST_WAIT);
    endsequence
    sequence early_pull_s;
        (state_q == SEQ_ST_HOLD && !sda_s && enable_q)
            ##1 (sda_low_q && state_q == SEQ_ST_TAIL);
    endsequence

    reload_source_a: assert property (reload |=> count == $past(reload_q))
        else $error("counter not loaded from reload register");
    buffer_start_a: assert property (buf_wr |=> state_q == SEQ_LOW
                                     && count == $past(reload_q) && run)
        else $error("buffer write did not start counter");
    stop_hold_a: assert property (state_q == SEQ_IDLE && !busy
                                  && $past(state_q) == SEQ_IDLE
                                  && $stable(enable_q) |-> $stable(scl_q))
        else $error("clock line moved while idle");
    half_reload_a: assert property ((state_q == SEQ_HIGH) && rollover
                                    && per_q != last_per |-> reload)
        else $error("no reload at half period");
    high_length_a: assert property ((state_q == SEQ_HIGH) && rollover
                                    |-> hi_len_q == {1'b0, loaded_q})
        else $error("high half not reload plus one cycles");
    rollover_zero_a: assert property (rollover |-> count == 8'h00 && run)
        else $error("rollover away from zero");
    early_start_a: assert property (start_request_s ##[1:1000]
                                    (state_q == SEQ_ST_HOLD && !sda_s
                                     && enable_q)
                                    |=> sda_low_q && $past(reload))
        else $error("data line not pulled early");
    early_pull_a: assert property ((state_q == SEQ_ST_HOLD && !sda_s
                                    && enable_q) |-> early_pull_s)
        else $error("start not shortened on low data");
    stretch_wait_a: assert property ((state_q == SEQ_HI_WAIT) && !scl_s
                                     && enable_q |-> !reload ##1
                                     state_q == SEQ_HI_WAIT)
        else $error("counter loaded while line held low");
    one_counter_a: assert property (run |-> enable_q && busy)
        else $error("counter runs with port idle");

endmodule : rate_generator

// >>> rate_gen_pkg.sv
// Overview of operation
// - one rate counter makes the serial clock whenever the port is bus host, in two-wire and four-wire mode.
// - software puts the reload value in the reload register and every counter load is taken from it.
// - a software write to the transfer buffer starts the counter with no further command.
// - when the operation ends the counter stops by itself and the clock line keeps its last level.
// - an internal reload strobe loads the counter twice per serial clock period, raised as the mode requires.
// - one serial clock period is exactly two rollovers of the counter.
// - the faster two-wire rate need not meet every fast-mode detail and is to be used with care.
// - during a start, a data line sampled low while counting resets the counter and pulls data low early.
// - after releasing the clock line the counter is loaded only once the line is sampled high.
package rate_gen_pkg;

    // ------------------------------------------------------------------
    // register indices
    // ------------------------------------------------------------------
    localparam logic [1:0] REG_RATE_RELOAD = 2'h0;
    localparam logic [1:0] REG_TRANSFER    = 2'h1;
    localparam logic [1:0] REG_CONTROL     = 2'h2;
    localparam logic [1:0] REG_STATUS      = 2'h3;

    // ------------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------------
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_TWO_WIRE_BIT = 1;
    localparam int CTRL_START_BIT  = 2;
    localparam int STAT_BUSY_BIT   = 0;
    localparam int STAT_SCL_BIT    = 1;
    localparam int STAT_SDA_BIT    = 2;
    localparam int STAT_DONE_BIT   = 3;

    localparam int         RELOAD_W        = 8;
    localparam logic [7:0] RELOAD_RESET    = 8'h00;
    localparam logic [7:0] BUFFER_RESET    = 8'h00;
    localparam logic [3:0] TWO_WIRE_CLOCKS = 4'h9;
    localparam logic [3:0] FOUR_WIRE_CLOCKS = 4'h8;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [1:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_t;

    typedef enum logic [2:0] {
        SEQ_IDLE     = 3'b000,
        SEQ_ST_WAIT  = 3'b001,
        SEQ_ST_HOLD  = 3'b010,
        SEQ_ST_TAIL  = 3'b011,
        SEQ_LOW      = 3'b100,
        SEQ_HI_WAIT  = 3'b101,
        SEQ_HIGH     = 3'b110
    } seq_state_t;

endpackage : rate_gen_pkg

// >>> rate_counter.sv
`timescale 1ns/1ns
module rate_counter #(
    parameter int unsigned W = 8
) (
    input  wire logic         core_clk,   // core clock
    input  wire logic         resetn,     // async reset, active low
    input  wire logic         reload,     // load strobe
    input  wire logic         run,        // count enable from sequencer
    input  wire logic [W-1:0] value,      // reload register contents
    output logic      [W-1:0] count,      // current count
    output logic              rollover    // count at zero while running
);
    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;

    // --------------------------------------------------------------
    // down counter
    // --------------------------------------------------------------
    // load wins over decrement so the next half period starts at once
    always_comb begin
        cnt_d = cnt_q;
        if (reload) begin
            cnt_d = value;
        end else if (run && cnt_q != '0) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // zero reached: tell the sequencer
    assign rollover = run && (cnt_q == '0);
    assign count    = cnt_q;

endmodule : rate_counter

// >>> bus_client_model.sv
`timescale 1ns/1ns
module bus_client_model (
    input  wire logic       core_clk,    // core clock
    input  wire logic       resetn,      // async reset, active low
    input  wire logic       scl_value,   // clock drive from port
    input  wire logic       scl_enable,  // clock drive enable
    input  wire logic       sda_value,   // data drive from port
    input  wire logic       sda_enable,  // data drive enable
    input  wire logic [7:0] stretch_len, // extra low cycles after each release cycle
    input  wire logic       sda_pull,    // client pulls data low
    output logic            scl_line,    // resolved clock line
    output logic            sda_line     // resolved data line
);
    logic [7:0] hold_q;
    logic [7:0] hold_d;
    logic       en_q;
    logic       stretch;

    // ----------------------------------------------------------------
    // clock stretching
    // ----------------------------------------------------------------
    // low already in the release cycle, so no high glitch reaches sync
    always_comb begin
        stretch = (hold_q != 8'h00) ||
                  (en_q && !scl_enable && stretch_len != 8'h00);
        hold_d  = (hold_q != 8'h00) ? hold_q - 8'h01 : 8'h00;
        if (en_q && !scl_enable) begin
            hold_d = stretch_len;
        end
    end

    // register the release detector
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            hold_q <= 8'h00;
            en_q   <= 1'b0;
        end else begin
            hold_q <= hold_d;
            en_q   <= scl_enable;
        end
    end

    // pulled-up wired-and lines, released level is high
    assign scl_line = (scl_enable ? scl_value : 1'b1) & ~stretch;
    assign sda_line = (sda_enable ? sda_value : 1'b1) & ~sda_pull;
endmodule : bus_client_model

// >>> serial_port_baud_generator_test.sv
`timescale 1ns/1ns
module serial_port_baud_generator_test;
    import rate_gen_pkg::*;
    logic       core_clk;
    logic       resetn;
    reg_req_t   req;
    logic [7:0] rd_data;
    logic       scl_line;
    logic       sda_line;
    logic       scl_value;
    logic       scl_enable;
    logic       sda_value;
    logic       sda_enable;
    logic       rollover;
    logic       op_done;
    logic       busy;
    logic [7:0] stretch_len;
    logic       sda_pull;
    logic [7:0] rd_v;
    logic [7:0] rl;
    int         error_cnt;
    int         compares;
    int         k;
    int         dur[2];
    int         rolls[2];
    int         rises[2];
    int         t_sda[2];

    rate_generator i_rate_generator (
        .core_clk(core_clk), .resetn(resetn), .req(req),
        .rd_data(rd_data), .scl_sense(scl_line), .scl_value(scl_value),
        .scl_enable(scl_enable), .sda_sense(sda_line),
        .sda_value(sda_value), .sda_enable(sda_enable),
        .rollover(rollover), .op_done(op_done), .busy(busy)
    );

    bus_client_model i_bus_client_model (
        .core_clk(core_clk), .resetn(resetn), .scl_value(scl_value),
        .scl_enable(scl_enable), .sda_value(sda_value),
        .sda_enable(sda_enable), .stretch_len(stretch_len),
        .sda_pull(sda_pull), .scl_line(scl_line), .sda_line(sda_line)
    );

    // ----------------------------------------------------------------
    // bench tasks
    // ----------------------------------------------------------------
    task check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task results;
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : results

    task reg_wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge core_clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        req.wr <= 1'b0;
    endtask : reg_wr

    // read data stand only in the cycle after the strobe
    task reg_rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge core_clk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        req.rd <= 1'b0;
        #1 d = rd_data;
    endtask : reg_rd

    // follow one operation from the cycle after its launch to its end
    task run(input int j);
        logic last;
        int   i;
        int   moved;
        dur[j] = 0; rolls[j] = 0; rises[j] = 0; t_sda[j] = 0; moved = 0;
        last = scl_line;
        for (i = 0; i < 5000; i++) begin
            #1;
            if (i == 0) check(busy, 1'b1);
            rolls[j] += int'(rollover);
            if (scl_line && !last) rises[j]++;
            last = scl_line;
            if (sda_enable && t_sda[j] == 0) t_sda[j] = i;
            if (op_done) begin
                dur[j] = i;
                break;
            end
            @(posedge core_clk);
        end
        if (dur[j] == 0) begin
            error_cnt++;
            results();
        end
        // the last half ends on the edge after the done pulse, so the
        // settled level is taken one edge later and must then hold
        @(posedge core_clk);
        #1 last = scl_line;
        repeat (8) begin
            @(posedge core_clk);
            #1 moved += int'(scl_line !== last);
        end
        check(busy, 1'b0);
        check(moved, 0);
    endtask : run

    // ----------------------------------------------------------------
    // stimulus
    // ----------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // test sequence
    initial begin
        resetn = 1'b0; req = '0; stretch_len = 8'h00; sda_pull = 1'b0;
        error_cnt = 0; compares = 0; rl = 8'h00;
        repeat (8) @(posedge core_clk);
        resetn <= 1'b1;
        reg_rd(REG_RATE_RELOAD, rd_v);
        check(rd_v, RELOAD_RESET);
        reg_rd(REG_STATUS, rd_v);
        check({rd_v[3], rd_v[0], scl_enable}, 3'h0);
        $display("reset values done");
        // four-wire bursts at two rates
        reg_wr(REG_CONTROL, 8'h01);
        for (k = 0; k < 2; k++) begin
            rl = (k == 0) ? 8'h03 : 8'h05;
            reg_wr(REG_RATE_RELOAD, rl);
            reg_rd(REG_RATE_RELOAD, rd_v);
            check(rd_v, rl);
            reg_wr(REG_TRANSFER, 8'ha0 + rl);
            run(0);
            check(dur[0], 2 * FOUR_WIRE_CLOCKS * (rl + 1) - 1);
            check(rolls[0], 2 * FOUR_WIRE_CLOCKS);
            check(rises[0], FOUR_WIRE_CLOCKS);
            reg_rd(REG_TRANSFER, rd_v);
            check(rd_v, 8'ha0 + rl);
        end
        $display("four-wire bursts done");
        // two-wire bursts, prompt then slow client; codes 0..2 avoided
        reg_wr(REG_RATE_RELOAD, 8'h03);
        reg_wr(REG_CONTROL, 8'h03);
        for (k = 0; k < 2; k++) begin
            stretch_len <= (k == 0) ? 8'h00 : 8'h04;
            reg_wr(REG_TRANSFER, 8'h5a);
            run(k);
            check(rolls[k], 2 * TWO_WIRE_CLOCKS);
            check(rises[k], TWO_WIRE_CLOCKS);
        end
        check(dur[1] - dur[0], TWO_WIRE_CLOCKS * 5);
        stretch_len <= 8'h00;
        reg_rd(REG_STATUS, rd_v);
        check({rd_v[3], rd_v[0]}, 2'h2);
        reg_wr(REG_STATUS, 8'h08);
        reg_rd(REG_STATUS, rd_v);
        check(rd_v[3], 1'b0);
        $display("two-wire bursts done");
        // start condition, plain then with data pulled low early
        reg_wr(REG_RATE_RELOAD, 8'h09);
        for (k = 0; k < 2; k++) begin
            reg_wr(REG_CONTROL, 8'h00);
            // start is only taken while the port is already enabled
            reg_wr(REG_CONTROL, 8'h03);
            reg_wr(REG_CONTROL, 8'h07);
            fork
                run(k);
                if (k == 1) begin
                    repeat (6) @(posedge core_clk);
                    sda_pull <= 1'b1;
                end
            join
            check({scl_line, sda_line}, 2'h0);
            sda_pull <= 1'b0;
        end
        check(t_sda[1] < t_sda[0], 1'b1);
        check(dur[1] - t_sda[1], dur[0] - t_sda[0]);
        $display("start conditions done");
        results();
    end
endmodule : serial_port_baud_generator_test
